// >>> include/mode_cfg_regs.svh
/*
 Offsets, field positions, reset values and timing counts for the
 channel mode-configuration block. Assumes inclusion by bare name.
*/
`ifndef MODE_CFG_REGS_SVH
`define MODE_CFG_REGS_SVH
// Register port selects (mode register window, command, data queues, status)
`define ADDR_MODE 2'h0
`define ADDR_CMD 2'h1
`define ADDR_DATA 2'h2
`define ADDR_STATUS 2'h3
// Mode register zero fields
`define MD0_WDOG_BIT 7
`define MD0_RXLVL_HI_BIT 6
`define MD0_TXLVL_LSB 4
`define MD0_FIFO_SIZE_BIT 3
`define MD0_BAUD_LSB 0
// Mode register one fields
`define MD1_RTS_CTRL_BIT 7
`define MD1_RXLVL_LO_BIT 6
`define MD1_ERR_MODE_BIT 5
`define MD1_PAR_MODE_LSB 3
`define MD1_PAR_TYPE_BIT 2
`define MD1_CHAR_LEN_LSB 0
// Reset values
`define MD0_RESET 8'h00
`define MD1_RESET 8'h00
`define MD2_RESET 8'h00
// Commands (upper nibble of command byte)
`define CMD_PTR_MD1 4'h1
`define CMD_ERR_RESET 4'h4
`define CMD_PTR_MD0 4'hB
// Watchdog: bit times of the receiver 1X clock
`define WDOG_BIT_TIMES 64
`endif

// >>> include/mode_cfg_pkg.sv
/*
 Types for the channel mode-configuration block.
 Assumes mode_cfg_regs.svh supplies the numbers.
*/
package mode_cfg_pkg;
   typedef enum logic [1:0] {
      PTR_MD0 = 2'b00,
      PTR_MD1 = 2'b01,
      PTR_MD2 = 2'b10
   } mode_ptr_t;
   typedef struct packed {
      logic wdog_en;
      logic rx_lvl_hi;
      logic [1:0] tx_lvl;
      logic fifo_big;
      logic [2:0] baud_grp;
   } mode_zero_t;
   typedef struct packed {
      logic rx_rts;
      logic rx_lvl_lo;
      logic err_block;
      logic [1:0] par_mode;
      logic par_type;
      logic [1:0] char_len;
   } mode_one_t;
   typedef struct packed {
      logic brk;
      logic frame;
      logic parity;
   } err_bits_t;
endpackage

// >>> core/mode_fifo.sv
/*
 Parameterised FIFO with valid/ready on both sides.
 Assumes a single synchronous clock and an active-low synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mode_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 8,
   parameter int CW = $clog2(DEPTH + 1)
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   // Fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // Drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out,
   // Occupancy
   output logic [CW-1:0] count_out
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [CW-1:0] count, next_count;
   logic push, pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   // Honest full and empty from the occupancy count
   always_comb begin
      push = in_valid_in && (count != CW'(DEPTH));
      pop = (count != '0) && out_ready_in;
      next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
      next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
      next_count = count + CW'(push) - CW'(pop);
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // Storage needs no reset; contents are guarded by count
   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   assign in_ready_out = (count != CW'(DEPTH));
   assign out_valid_out = (count != '0);
   assign out_data_out = mem[rd_ptr];
   assign count_out = count;
endmodule
`default_nettype wire

// >>> core/uart_channel_mode_config.sv
/*
 Per-channel mode configuration of a dual UART: mode registers behind an
 auto-advancing pointer, fill-level interrupt requests, receiver watchdog,
 receiver flow control of request-to-send and error accumulation.
 Assumes a parallel host port with one-cycle read/write strobes, and a
 receiver core supplying characters, start-bit strobes and 1X bit ticks.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mode_cfg_regs.svh"
// Function
// (RULE_01) Host issues the pointer-to-zero command before touching mode register zero.
// (RULE_02) Watchdog enabled: receive interrupt after 64 idle receiver bit times.
// (RULE_03) Small FIFO receive levels: 1, 3, 6 or 8 bytes held.
// (RULE_04) Large FIFO receive levels: 1, 128, 192 or 256 bytes held.
// (RULE_05) Small FIFO transmit levels: 8, 4, 6 or 1 positions empty.
// (RULE_06) Large FIFO transmit levels: 256, 128, 192 or 1 positions empty.
// (RULE_07) After reset receive queue is empty; default level asks at one byte.
// (RULE_08) Default transmit level asks only when empty and enabled; drops on load.
// (RULE_09) FIFO size bit picks 8 or 256 entries and level interpretation.
// (RULE_10) Baud group is normal, extended one or extended two only.
// (RULE_11) Host writes zero to low four bits of zero register on channel B.
// (RULE_12) Parity mode: with, forced, none or multi-drop.
// (RULE_13) Character length 5, 6, 7 or 8 data bits.
// (RULE_14) Block mode errors stay until error-reset command or receiver reset.
// (RULE_15) Reset or set-pointer selects register one; its access advances to two.
// (RULE_16) Receiver-controlled RTS negates on start bit with full queue; reasserts later.
// (RULE_17) Accesses to register two leave the pointer alone.
// (RULE_18) Character mode shows top character errors; block mode ORs them.
// (RULE_19) Parity type selects even/odd, forced polarity, or address bit polarity.
// (RULE_20) Each channel keeps its own mode register copies.
// (RULE_21) Level interrupt conditions are evaluated every clock.
module uart_channel_mode_config
   import mode_cfg_pkg::*;
#(
   parameter int SMALL_DEPTH = 8,
   parameter int LARGE_DEPTH = 256,
   parameter bit CHANNEL_B = 1'b0
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   // Host port
   input wire logic [1:0] addr_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out,
   // Transmit path
   input wire logic tx_enable_in,
   input wire logic tx_take_in,
   output logic tx_char_valid_out,
   output logic [7:0] tx_char_out,
   // Receive path
   input wire logic rx_bit_tick_in,
   input wire logic rx_start_in,
   input wire logic rx_char_valid_in,
   input wire logic [7:0] rx_char_in,
   input wire logic [2:0] rx_err_in,
   input wire logic rx_reset_in,
   input wire logic rts_opr_in,
   // Status and requests
   output logic rx_has_data,
   output logic rx_fifo_full_flag,
   output logic tx_has_space,
   output logic rx_irq_out,
   output logic tx_irq_out,
   output logic request_to_send_out_n,
   output err_bits_t err_status_out,
   // Line settings
   output mode_zero_t mode_zero_out,
   output mode_one_t mode_one_out,
   output logic [7:0] mode_two_out
);
   localparam int CW = $clog2(LARGE_DEPTH + 1);
   localparam int WW = $clog2(`WDOG_BIT_TIMES + 1);

   // Per-channel register copies live in each instance [RULE_20]
   mode_zero_t channel_mode_zero, next_mode_zero;
   mode_one_t channel_mode_one, next_mode_one;
   logic [7:0] channel_mode_two, next_mode_two;
   mode_ptr_t mode_ptr, next_mode_ptr;
   logic [WW-1:0] wdog_cnt, next_wdog_cnt;
   logic wdog_fire, next_wdog_fire;
   logic rts_hold, next_rts_hold;
   err_bits_t err_acc, next_err_acc;
   logic [7:0] rdata, next_rdata;
   logic rx_irq, next_rx_irq, tx_irq, next_tx_irq;
   logic rx_has, next_rx_has, rx_full, next_rx_full, tx_room, next_tx_room;
   logic rts_n, next_rts_n;
   err_bits_t err_out, next_err_out;

   logic [CW-1:0] rx_count, tx_count;
   logic rx_out_valid, rx_pop, tx_in_ready, tx_push;
   logic [10:0] rx_head;
   logic [7:0] tx_head;
   logic [CW-1:0] depth;
   logic mode_wr, mode_rd, cmd_wr;

   function automatic logic [CW-1:0] rx_level(input logic [1:0] code, input logic big);
      unique case ({big, code})
         3'b000: rx_level = CW'(1);
         3'b001: rx_level = CW'(3);
         3'b010: rx_level = CW'(6);
         3'b011: rx_level = CW'(SMALL_DEPTH);
         3'b100: rx_level = CW'(1);
         3'b101: rx_level = CW'(128);
         3'b110: rx_level = CW'(192);
         3'b111: rx_level = CW'(LARGE_DEPTH);
      endcase
   endfunction

   function automatic logic [CW-1:0] tx_level(input logic [1:0] code, input logic big);
      unique case ({big, code})
         3'b000: tx_level = CW'(SMALL_DEPTH);
         3'b001: tx_level = CW'(4);
         3'b010: tx_level = CW'(6);
         3'b011: tx_level = CW'(1);
         3'b100: tx_level = CW'(LARGE_DEPTH);
         3'b101: tx_level = CW'(128);
         3'b110: tx_level = CW'(192);
         3'b111: tx_level = CW'(1);
      endcase
   endfunction

   // Queue depth follows the size bit; both queues share it [RULE_09]
   assign depth = channel_mode_zero.fifo_big ? CW'(LARGE_DEPTH) : CW'(SMALL_DEPTH);
   assign mode_wr = wr_in && (addr_in == `ADDR_MODE);
   assign mode_rd = rd_in && (addr_in == `ADDR_MODE);
   assign cmd_wr = wr_in && (addr_in == `ADDR_CMD);
   assign rx_pop = rd_in && (addr_in == `ADDR_DATA) && rx_out_valid;
   // A write into a full queue is dropped
   assign tx_push = wr_in && (addr_in == `ADDR_DATA) && tx_in_ready && (tx_count < depth);

   // Receive queue: data plus three error bits per character
   mode_fifo #(.WIDTH(11), .DEPTH(LARGE_DEPTH)) rx_queue (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in && !rx_reset_in),
      .in_valid_in(rx_char_valid_in && (rx_count < depth)),
      .in_ready_out(),
      .in_data_in({rx_err_in, rx_char_in}),
      .out_valid_out(rx_out_valid),
      .out_ready_in(rx_pop),
      .out_data_out(rx_head),
      .count_out(rx_count)
   );

   // Transmit queue drained by the transmitter, which may stall
   mode_fifo #(.WIDTH(8), .DEPTH(LARGE_DEPTH)) tx_queue (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .in_valid_in(tx_push),
      .in_ready_out(tx_in_ready),
      .in_data_in(wdata_in),
      .out_valid_out(tx_char_valid_out),
      .out_ready_in(tx_take_in),
      .out_data_out(tx_head),
      .count_out(tx_count)
   );
   assign tx_char_out = tx_head;

   // Mode registers and pointer
   always_comb begin
      next_mode_zero = channel_mode_zero;
      next_mode_one = channel_mode_one;
      next_mode_two = channel_mode_two;
      next_mode_ptr = mode_ptr;
      if (cmd_wr && wdata_in[7:4] == `CMD_PTR_MD1) begin
         next_mode_ptr = PTR_MD1; // [RULE_15]
      end else if (cmd_wr && wdata_in[7:4] == `CMD_PTR_MD0) begin
         next_mode_ptr = PTR_MD0; // [RULE_01]
      end else if (mode_wr || mode_rd) begin
         unique case (mode_ptr)
            PTR_MD0: begin
               if (mode_wr) begin
                  next_mode_zero = mode_zero_t'(wdata_in);
                  // Channel B ignores the low nibble [RULE_11]
                  if (CHANNEL_B) begin
                     next_mode_zero.fifo_big = 1'b0;
                     next_mode_zero.baud_grp = 3'h0;
                  end
               end
               next_mode_ptr = PTR_MD1;
            end
            PTR_MD1: begin
               if (mode_wr) begin
                  next_mode_one = mode_one_t'(wdata_in);
               end
               next_mode_ptr = PTR_MD2; // [RULE_15]
            end
            PTR_MD2: begin
               if (mode_wr) begin
                  next_mode_two = wdata_in;
               end
               next_mode_ptr = PTR_MD2; // [RULE_17]
            end
            default: next_mode_ptr = PTR_MD1;
         endcase
      end
   end

   // Read data, captured one cycle after the strobe
   always_comb begin
      next_rdata = rdata;
      if (rd_in) begin
         unique case (addr_in)
            `ADDR_MODE: begin
               unique case (mode_ptr)
                  PTR_MD0: next_rdata = channel_mode_zero;
                  PTR_MD1: next_rdata = channel_mode_one;
                  default: next_rdata = channel_mode_two;
               endcase
            end
            `ADDR_DATA: next_rdata = rx_out_valid ? rx_head[7:0] : 8'h00;
            `ADDR_STATUS: next_rdata = {err_out, 2'b00, tx_room, rx_full, rx_has};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // Watchdog counts receiver bit times since the last queue read [RULE_02]
   always_comb begin
      next_wdog_cnt = wdog_cnt;
      next_wdog_fire = wdog_fire;
      if (!channel_mode_zero.wdog_en || rx_pop || !rx_out_valid || rx_reset_in) begin
         next_wdog_cnt = '0;
         next_wdog_fire = 1'b0;
      end else if (rx_bit_tick_in && wdog_cnt != WW'(`WDOG_BIT_TIMES)) begin
         next_wdog_cnt = wdog_cnt + WW'(1);
         if (wdog_cnt == WW'(`WDOG_BIT_TIMES - 1)) begin
            next_wdog_fire = 1'b1;
         end
      end
   end

   // Level requests and status, refreshed every cycle [RULE_21]
   always_comb begin
      logic [1:0] rcode;
      logic [CW-1:0] free;
      rcode = {channel_mode_zero.rx_lvl_hi, channel_mode_one.rx_lvl_lo};
      free = depth - tx_count;
      // Empty queue after reset never meets level one [RULE_07]
      next_rx_irq = (rx_count >= rx_level(rcode, channel_mode_zero.fifo_big)) // [RULE_03] [RULE_04]
         || wdog_fire;
      // Code 00 asks only when fully empty and enabled [RULE_08]
      next_tx_irq = tx_enable_in
         && (free >= tx_level(channel_mode_zero.tx_lvl, channel_mode_zero.fifo_big)); // [RULE_05] [RULE_06]
      next_rx_has = (rx_count != '0);
      next_rx_full = (rx_count == depth);
      next_tx_room = tx_enable_in && (free != '0);
   end

   // Flow control hold: set at a start bit while full, released once a slot frees [RULE_16]
   always_comb begin
      next_rts_hold = rts_hold;
      if (!channel_mode_one.rx_rts || rx_count < depth) begin
         next_rts_hold = 1'b0;
      end else if (rx_start_in) begin
         next_rts_hold = 1'b1;
      end
      // Output level: asserted (low) per output-port bit unless held off
      next_rts_n = !rts_opr_in || next_rts_hold;
   end

   // Error status: head character only, or accumulated in block mode [RULE_18]
   always_comb begin
      err_bits_t head;
      head = rx_out_valid ? err_bits_t'(rx_head[10:8]) : '0;
      next_err_acc = err_acc;
      if (rx_reset_in || (cmd_wr && wdata_in[7:4] == `CMD_ERR_RESET)) begin
         next_err_acc = '0; // [RULE_14]
      end else if (rx_pop) begin
         next_err_acc = err_acc | head;
      end
      next_err_out = channel_mode_one.err_block ? (next_err_acc | head) : head;
   end

   // State registers; reset points the pointer at register one [RULE_15]
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         channel_mode_zero <= mode_zero_t'(`MD0_RESET);
         channel_mode_one <= mode_one_t'(`MD1_RESET);
         channel_mode_two <= `MD2_RESET;
         mode_ptr <= PTR_MD1;
         wdog_cnt <= '0;
         wdog_fire <= 1'b0;
         rts_hold <= 1'b0;
         err_acc <= '0;
         rdata <= 8'h00;
         rx_irq <= 1'b0;
         tx_irq <= 1'b0;
         rx_has <= 1'b0;
         rx_full <= 1'b0;
         tx_room <= 1'b0;
         rts_n <= 1'b1;
         err_out <= '0;
      end else begin
         channel_mode_zero <= next_mode_zero;
         channel_mode_one <= next_mode_one;
         channel_mode_two <= next_mode_two;
         mode_ptr <= next_mode_ptr;
         wdog_cnt <= next_wdog_cnt;
         wdog_fire <= next_wdog_fire;
         rts_hold <= next_rts_hold;
         err_acc <= next_err_acc;
         rdata <= next_rdata;
         rx_irq <= next_rx_irq;
         tx_irq <= next_tx_irq;
         rx_has <= next_rx_has;
         rx_full <= next_rx_full;
         tx_room <= next_tx_room;
         rts_n <= next_rts_n;
         err_out <= next_err_out;
      end
   end

   // Settings pass to the line logic straight from the registers
   // Baud group, parity mode/type, length are decoded downstream [RULE_10] [RULE_12] [RULE_13] [RULE_19]
   assign mode_zero_out = channel_mode_zero;
   assign mode_one_out = channel_mode_one;
   assign mode_two_out = channel_mode_two;
   assign rdata_out = rdata;
   assign rx_has_data = rx_has;
   assign rx_fifo_full_flag = rx_full;
   assign tx_has_space = tx_room;
   assign rx_irq_out = rx_irq;
   assign tx_irq_out = tx_irq;
   assign request_to_send_out_n = rts_n;
   assign err_status_out = err_out;
endmodule
`default_nettype wire

// >>> testbench/mode_cfg_chk.sv
/*
 Port-level assertions for the channel mode-configuration block.
 Assumes the package and register header are compiled first; bound below.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mode_cfg_regs.svh"
module mode_cfg_chk
   import mode_cfg_pkg::*;
(
   // Clock, reset and host strobes
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic wr_in,
   input wire logic [1:0] addr_in,
   // Receive and transmit controls
   input wire logic tx_enable_in,
   input wire logic rx_char_valid_in,
   input wire logic rx_reset_in,
   input wire logic rts_opr_in,
   // Watched outputs
   input wire logic rx_has_data,
   input wire logic rx_fifo_full_flag,
   input wire logic tx_has_space,
   input wire logic rx_irq_out,
   input wire logic tx_irq_out,
   input wire logic request_to_send_out_n,
   input wire err_bits_t err_status_out,
   input wire mode_one_t mode_one_out,
   input wire logic [7:0] mode_two_out
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!resetn_in);

   property p_reset_quiet;
      $rose(resetn_in) |-> request_to_send_out_n && !rx_irq_out && !tx_irq_out;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not idle after reset");

   property p_tx_irq_enabled;
      tx_irq_out |-> $past(tx_enable_in);
   endproperty
   a_tx_irq_enabled: assert property (p_tx_irq_enabled) else $error("tx irq while disabled");

   property p_tx_irq_space;
      tx_irq_out |-> tx_has_space;
   endproperty
   a_tx_irq_space: assert property (p_tx_irq_space) else $error("tx irq with no space");

   property p_full_irq;
      rx_fifo_full_flag |-> rx_irq_out && rx_has_data;
   endproperty
   a_full_irq: assert property (p_full_irq) else $error("full queue without rx irq");

   property p_irq_data;
      rx_irq_out |-> rx_has_data;
   endproperty
   a_irq_data: assert property (p_irq_data) else $error("rx irq with empty queue");

   // A mode register only moves on a write to the mode window
   property p_one_hold;
      !$stable(mode_one_out) |-> $past(wr_in) && $past(addr_in) == `ADDR_MODE;
   endproperty
   a_one_hold: assert property (p_one_hold) else $error("mode one moved without write");

   property p_two_hold;
      !$stable(mode_two_out) |-> $past(wr_in) && $past(addr_in) == `ADDR_MODE;
   endproperty
   a_two_hold: assert property (p_two_hold) else $error("mode two moved without write");

   property p_rts_opr;
      !$past(rts_opr_in) |-> request_to_send_out_n;
   endproperty
   a_rts_opr: assert property (p_rts_opr) else $error("rts asserted without port bit");

   property p_rts_flow;
      $rose(request_to_send_out_n) && $past(rts_opr_in) |-> mode_one_out.rx_rts;
   endproperty
   a_rts_flow: assert property (p_rts_flow) else $error("rts negated without flow mode");

   property p_err_clear;
      rx_reset_in ##1 !rx_char_valid_in [*2] |=> err_status_out == 3'h0;
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("errors kept after rx reset");
endmodule
bind uart_channel_mode_config mode_cfg_chk chk (.*);
`default_nettype wire

// >>> testbench/host_model.sv
/*
 Host processor on the parallel register port: one-cycle strobes.
 Assumes inputs change at the falling edge and the device samples at the rising one.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mode_cfg_regs.svh"
module host_model (
   // Clock and read data
   input wire logic ref_clk_in,
   input wire logic [7:0] rdata_in,
   // Strobes toward the device
   output logic [1:0] addr_out,
   output logic wr_out,
   output logic rd_out,
   output logic [7:0] wdata_out
);
   initial begin
      addr_out = 2'h0;
      wr_out = 1'b0;
      rd_out = 1'b0;
      wdata_out = 8'h00;
   end
   // Released bus shows inverted values so stale data never looks valid
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(negedge ref_clk_in);
      addr_out = a;
      wdata_out = d;
      wr_out = 1'b1;
      @(negedge ref_clk_in);
      wr_out = 1'b0;
      addr_out = ~a;
      wdata_out = ~d;
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(negedge ref_clk_in);
      addr_out = a;
      rd_out = 1'b1;
      @(negedge ref_clk_in);
      rd_out = 1'b0;
      addr_out = ~a;
      d = rdata_in;
   endtask
   // Register zero is only reached through the pointer command
   task automatic ptr_zero;
      wr(`ADDR_CMD, 8'hB0);
   endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
/*
 Self-checking bench for the mode-configuration block, channel A instance.
 Assumes package, header, checker and host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mode_cfg_regs.svh"
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin fails++; $display("wrong value at %0t: %s", $time, m); end end
module tb
   import mode_cfg_pkg::*;
;
   logic ref_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic tx_enable_in = 1'b0, tx_take_in = 1'b0, rx_bit_tick_in = 1'b0, rx_start_in = 1'b0;
   logic rx_char_valid_in = 1'b0, rx_reset_in = 1'b0, rts_opr_in = 1'b0;
   logic [2:0] rx_err_in = 3'h0;
   logic [7:0] rdata_out, mode_two_out;
   logic rx_has_data, rx_fifo_full_flag, tx_has_space, rx_irq_out, tx_irq_out;
   logic request_to_send_out_n, tx_char_valid_out;
   err_bits_t err_status_out;
   mode_zero_t mode_zero_out;
   mode_one_t mode_one_out;
   wire [1:0] addr_in;
   wire wr_in, rd_in;
   wire [7:0] wdata_in;
   int fails = 0, comparisons = 0;

   always #2 ref_clk_in = ~ref_clk_in;

   host_model host (.ref_clk_in(ref_clk_in), .rdata_in(rdata_out), .addr_out(addr_in),
      .wr_out(wr_in), .rd_out(rd_in), .wdata_out(wdata_in));

   uart_channel_mode_config dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in),
      .rdata_out(rdata_out), .tx_enable_in(tx_enable_in), .tx_take_in(tx_take_in),
      .tx_char_valid_out(tx_char_valid_out), .tx_char_out(), .rx_bit_tick_in(rx_bit_tick_in),
      .rx_start_in(rx_start_in), .rx_char_valid_in(rx_char_valid_in), .rx_char_in(8'hA5),
      .rx_err_in(rx_err_in), .rx_reset_in(rx_reset_in), .rts_opr_in(rts_opr_in),
      .rx_has_data(rx_has_data), .rx_fifo_full_flag(rx_fifo_full_flag),
      .tx_has_space(tx_has_space), .rx_irq_out(rx_irq_out), .tx_irq_out(tx_irq_out),
      .request_to_send_out_n(request_to_send_out_n), .err_status_out(err_status_out),
      .mode_zero_out(mode_zero_out), .mode_one_out(mode_one_out),
      .mode_two_out(mode_two_out));

   // Shared stimulus helpers
   task automatic wt(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask
   task automatic push(input logic [2:0] e);
      @(negedge ref_clk_in);
      rx_char_valid_in = 1'b1;
      rx_err_in = e;
      @(negedge ref_clk_in);
      rx_char_valid_in = 1'b0;
   endtask
   // Low nibble of register zero is free on channel A only
   task automatic modes(input logic [7:0] m0, input logic [7:0] m1);
      host.ptr_zero();
      host.wr(`ADDR_MODE, m0);
      host.wr(`ADDR_MODE, m1);
      rx_reset_in = 1'b1;
      wt(1);
      rx_reset_in = 1'b0;
      wt(2);
   endtask

   task automatic t_reset;
      logic [7:0] d;
      `CHK(request_to_send_out_n, 1'b1, "rts after reset")
      `CHK(rx_has_data, 1'b0, "rx empty after reset")
      host.rd(`ADDR_MODE, d);
      `CHK(d, 8'h00, "first mode read")
      host.wr(`ADDR_MODE, 8'h5A);
      `CHK(mode_two_out, 8'h5A, "pointer at two")
      host.wr(`ADDR_MODE, 8'h3C);
      `CHK(mode_two_out, 8'h3C, "pointer stays at two")
      tx_enable_in = 1'b1;
      wt(3);
      `CHK(tx_irq_out, 1'b1, "tx irq on enable")
      host.wr(`ADDR_DATA, 8'h11);
      wt(2);
      `CHK(tx_irq_out, 1'b0, "tx irq withdrawn")
      tx_take_in = 1'b1;
      wt(3);
      tx_take_in = 1'b0;
      $display("test reset done");
   endtask

   task automatic t_fields;
      logic [2:0] grp [4] = '{3'h0, 3'h1, 3'h4, 3'h1};
      logic [7:0] d;
      for (int i = 0; i < 4; i++) begin
         modes({5'h00, grp[i]}, {3'h0, 2'(i), 1'(i), 2'(i)});
         `CHK(mode_zero_out.baud_grp, grp[i], "baud group")
         `CHK(mode_one_out.par_mode, 2'(i), "parity mode")
         `CHK(mode_one_out.par_type, 1'(i), "parity type")
         `CHK(mode_one_out.char_len, 2'(i), "char length")
      end
      host.wr(`ADDR_CMD, 8'h10);
      host.wr(`ADDR_MODE, 8'h07);
      `CHK(mode_one_out, 8'h07, "pointer command to one")
      host.ptr_zero();
      host.rd(`ADDR_MODE, d);
      `CHK(d, 8'h01, "read of register zero")
      $display("test fields done");
   endtask

   task automatic t_rx_levels;
      int thr [4] = '{1, 3, 6, 8};
      for (int c = 0; c < 4; c++) begin
         modes({1'b0, c[1], 6'h00}, {1'b0, c[0], 6'h00});
         for (int n = 1; n <= 8; n++) begin
            push(3'h0);
            wt(2);
            `CHK(rx_irq_out, n >= thr[c], "rx small level")
         end
         `CHK(rx_fifo_full_flag, 1'b1, "small queue full at 8")
      end
      // Large queue, code 01 asks at 128
      modes(8'h08, 8'h40);
      repeat (127) push(3'h0);
      wt(2);
      `CHK(rx_irq_out, 1'b0, "rx large below level")
      push(3'h0);
      wt(2);
      `CHK(rx_irq_out, 1'b1, "rx large at level")
      $display("test rx levels done");
   endtask

   task automatic t_tx_levels;
      int thr [4] = '{8, 4, 6, 1};
      for (int c = 0; c < 4; c++) begin
         modes({2'b00, c[1:0], 4'h0}, 8'h00);
         for (int n = 0; n <= 8; n++) begin
            `CHK(tx_irq_out, (8 - n) >= thr[c], "tx small level")
            host.wr(`ADDR_DATA, 8'(n));
            wt(1);
         end
         `CHK(tx_has_space, 1'b0, "tx queue refuses when full")
         tx_take_in = 1'b1;
         wt(10);
         tx_take_in = 1'b0;
         wt(2);
         `CHK(tx_char_valid_out, 1'b0, "tx queue drained")
      end
      $display("test tx levels done");
   endtask

   task automatic t_watchdog;
      logic [7:0] d;
      modes(8'hC0, 8'h40);
      push(3'h0);
      for (int t = 0; t < 68; t++) begin
         if (t == 60)
            `CHK(rx_irq_out, 1'b0, "watchdog early")
         @(negedge ref_clk_in);
         rx_bit_tick_in = 1'b1;
         @(negedge ref_clk_in);
         rx_bit_tick_in = 1'b0;
      end
      wt(2);
      `CHK(rx_irq_out, 1'b1, "watchdog fired")
      host.rd(`ADDR_DATA, d);
      wt(2);
      `CHK(rx_irq_out, 1'b0, "read clears request")
      $display("test watchdog done");
   endtask

   task automatic t_rts;
      logic [7:0] d;
      modes(8'h00, 8'h80);
      rts_opr_in = 1'b1;
      wt(2);
      `CHK(request_to_send_out_n, 1'b0, "rts asserted")
      repeat (8) push(3'h0);
      rx_start_in = 1'b1;
      wt(1);
      rx_start_in = 1'b0;
      wt(2);
      `CHK(request_to_send_out_n, 1'b1, "rts negated when full")
      host.rd(`ADDR_DATA, d);
      wt(3);
      `CHK(request_to_send_out_n, 1'b0, "rts back after read")
      rts_opr_in = 1'b0;
      $display("test rts done");
   endtask

   task automatic t_errors;
      logic [7:0] d;
      modes(8'h00, 8'h20);
      push(3'h2);
      push(3'h0);
      host.rd(`ADDR_DATA, d);
      wt(2);
      `CHK(err_status_out, 3'h2, "block errors kept")
      host.wr(`ADDR_CMD, 8'h40);
      wt(2);
      `CHK(err_status_out, 3'h0, "error reset command")
      modes(8'h00, 8'h00);
      push(3'h4);
      push(3'h0);
      host.rd(`ADDR_DATA, d);
      wt(2);
      `CHK(err_status_out, 3'h0, "char mode shows head only")
      $display("test errors done");
   endtask

   task automatic wrap_up;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence after four cycles of reset
   initial begin
      wt(4);
      resetn_in = 1'b1;
      t_reset();
      t_fields();
      t_rx_levels();
      t_tx_levels();
      t_watchdog();
      t_rts();
      t_errors();
      wrap_up();
   end

   // Hang guard, well beyond the fewer than a thousand cycles the tests need
   initial begin
      #200000;
      fails++;
      wrap_up();
   end
endmodule
`default_nettype wire
